/* rtl/ts_low_stamp_pkg.sv */
// constants for the low-temperature minutes and hours time stamp block
package ts_low_stamp_pkg;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] MINUTES_INDEX = 8'h1a;
  localparam logic [7:0] HOURS_INDEX = 8'h1b;
  localparam logic [7:0] CONTROL_INDEX = 8'h10;
  localparam logic [9:0] MINUTES_ADDR = {MINUTES_INDEX, 2'b00};
  localparam logic [9:0] HOURS_ADDR = {HOURS_INDEX, 2'b00};
  localparam logic [9:0] CONTROL_ADDR = {CONTROL_INDEX, 2'b00};

  // ****************************************************************
  // field layouts
  // ****************************************************************
  localparam logic [7:0] MINUTES_MASK = 8'h7f;
  localparam logic [7:0] HOURS_MASK = 8'h3f;
  localparam int ENABLE_BIT = 0;
  localparam int LAST_SELECT_BIT = 1;
  localparam int CLEAR_BIT = 2;
  localparam int STAMP_VALID_BIT = 3;
  localparam logic [3:0] MINUTES_TENS_MAX = 4'h5;
  localparam logic [3:0] HOURS_TENS_MAX = 4'h2;
  localparam logic [3:0] UNITS_MAX = 4'h9;
  localparam logic [3:0] HOURS_UNITS_MAX_AT_TOP = 4'h3;

  // ****************************************************************
  // reset values and bus answers
  // ****************************************************************
  localparam logic [7:0] STAMP_RESET = 8'h00;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic LAST_SELECT_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage : ts_low_stamp_pkg

/* rtl/bcd_stamp_reg.sv */
// one stamp register with clear and load
`timescale 1ns/10ps
`default_nettype none
module bcd_stamp_reg (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] mask,
  input wire logic [7:0] din,
  output logic [7:0] q
);

  typedef struct packed {
    logic [7:0] value;
  } stamp_s;

  stamp_s s;
  stamp_s next_s;

  // ****************************************************************
  // next value
  // ****************************************************************
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.value = ts_low_stamp_pkg::STAMP_RESET; // R6
    end
    if (load) begin
      next_s.value = din & mask; // R2 R4
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s.value <= ts_low_stamp_pkg::STAMP_RESET; // R6
    end else begin
      s <= next_s;
    end
  end

  assign q = s.value;

endmodule : bcd_stamp_reg
`default_nettype wire

/* rtl/temp_low_stamp_min_hour.sv */
// low-temperature time stamp of minutes and hours behind an axi4-lite slave
//
// Notes on behaviour
// R1: on a low-temperature event the current minutes are copied as two bcd digits into bits 6:0 of the minutes stamp.
// R2: the minutes stamp only ever holds bcd 00 to 59 and its bit 7 always reads zero.
// R3: on a low-temperature event the current hours are copied as two bcd digits into bits 5:0 of the hours stamp.
// R4: the hours stamp only ever holds bcd 00 to 23 and its bits 7:6 always read zero.
// R5: both stamp registers are read-only and a write to them leaves them unchanged.
// R6: capture happens only while enabled, keeping first or latest event per the selector; clear bit and reset zero both.
`timescale 1ns/10ps
`default_nettype none
module temp_low_stamp_min_hour (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] clockMinutes,
  input wire logic [7:0] clockHours,
  input wire logic lowEvent
);

  typedef struct packed {
    logic awReady;
    logic wReady;
    logic awHeld;
    logic wHeld;
    logic [9:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic enable;
    logic lastSelect;
    logic stampValid;
  } state_s;

  state_s s;
  state_s next_s;

  logic clearPulse;
  logic capture;
  logic minutesOk;
  logic hoursOk;
  logic [7:0] stampMinutes;
  logic [7:0] stampHours;

  // ****************************************************************
  // bcd range checks on the live clock values
  // ****************************************************************
  always_comb begin
    minutesOk = 1'b1;
    hoursOk = 1'b1;
    if (clockMinutes[7]) begin
      minutesOk = 1'b0; // R2
    end else if ({1'b0, clockMinutes[6:4]} > ts_low_stamp_pkg::MINUTES_TENS_MAX) begin
      minutesOk = 1'b0; // R2
    end else if (clockMinutes[3:0] > ts_low_stamp_pkg::UNITS_MAX) begin
      minutesOk = 1'b0; // R2
    end
    if (clockHours[7:6] != 2'b00) begin
      hoursOk = 1'b0; // R4
    end else if ({2'b00, clockHours[5:4]} > ts_low_stamp_pkg::HOURS_TENS_MAX) begin
      hoursOk = 1'b0; // R4
    end else if (clockHours[3:0] > ts_low_stamp_pkg::UNITS_MAX) begin
      hoursOk = 1'b0; // R4
    end else if (({2'b00, clockHours[5:4]} == ts_low_stamp_pkg::HOURS_TENS_MAX) &&
                 (clockHours[3:0] > ts_low_stamp_pkg::HOURS_UNITS_MAX_AT_TOP)) begin
      hoursOk = 1'b0; // R4
    end
  end

  // ****************************************************************
  // capture decision
  // ****************************************************************
  always_comb begin
    capture = lowEvent && s.enable && minutesOk && hoursOk && (s.lastSelect || !s.stampValid); // R6
  end

  // ****************************************************************
  // bus and control next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    clearPulse = 1'b0;

    // write response handshake
    if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end

    // address and data are taken independently
    if (awvalid && s.awReady) begin
      next_s.awHeld = 1'b1;
      next_s.awAddrHeld = awaddr;
    end
    if (wvalid && s.wReady) begin
      next_s.wHeld = 1'b1;
      next_s.wDataHeld = wdata;
      next_s.wStrbHeld = wstrb;
    end

    // perform the write once both halves are held
    if (s.awHeld && s.wHeld && !s.bValid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = ts_low_stamp_pkg::RESP_OKAY;
      if (s.awAddrHeld == ts_low_stamp_pkg::CONTROL_ADDR) begin
        if (s.wStrbHeld[0]) begin
          next_s.enable = s.wDataHeld[ts_low_stamp_pkg::ENABLE_BIT]; // R6
          next_s.lastSelect = s.wDataHeld[ts_low_stamp_pkg::LAST_SELECT_BIT]; // R6
          clearPulse = s.wDataHeld[ts_low_stamp_pkg::CLEAR_BIT]; // R6
        end
      end else if (s.awAddrHeld == ts_low_stamp_pkg::MINUTES_ADDR) begin
        next_s.bResp = ts_low_stamp_pkg::RESP_OKAY; // R5
      end else if (s.awAddrHeld == ts_low_stamp_pkg::HOURS_ADDR) begin
        next_s.bResp = ts_low_stamp_pkg::RESP_OKAY; // R5
      end else begin
        next_s.bResp = ts_low_stamp_pkg::RESP_DECERR;
      end
    end

    // stamp-present flag, capture wins over clear
    if (clearPulse) begin
      next_s.stampValid = 1'b0; // R6
    end
    if (capture) begin
      next_s.stampValid = 1'b1; // R6
    end

    // read channel
    if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
    end
    if (arvalid && s.arReady) begin
      next_s.rValid = 1'b1;
      next_s.rResp = ts_low_stamp_pkg::RESP_OKAY;
      next_s.rData = 32'h00000000;
      if (araddr == ts_low_stamp_pkg::MINUTES_ADDR) begin
        next_s.rData = {24'h000000, stampMinutes & ts_low_stamp_pkg::MINUTES_MASK}; // R2
      end else if (araddr == ts_low_stamp_pkg::HOURS_ADDR) begin
        next_s.rData = {24'h000000, stampHours & ts_low_stamp_pkg::HOURS_MASK}; // R4
      end else if (araddr == ts_low_stamp_pkg::CONTROL_ADDR) begin
        next_s.rData[ts_low_stamp_pkg::ENABLE_BIT] = s.enable;
        next_s.rData[ts_low_stamp_pkg::LAST_SELECT_BIT] = s.lastSelect;
        next_s.rData[ts_low_stamp_pkg::STAMP_VALID_BIT] = s.stampValid;
      end else begin
        next_s.rResp = ts_low_stamp_pkg::RESP_DECERR;
      end
    end

    // ready only while a slot is free
    next_s.awReady = !next_s.awHeld && !next_s.bValid;
    next_s.wReady = !next_s.wHeld && !next_s.bValid;
    next_s.arReady = !next_s.rValid;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      s <= '0;
      s.enable <= ts_low_stamp_pkg::ENABLE_RESET;
      s.lastSelect <= ts_low_stamp_pkg::LAST_SELECT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // stamp storage
  // ****************************************************************
  bcd_stamp_reg minutesStamp (
    .mclk(mclk),
    .srst(srst),
    .clear(clearPulse),
    .load(capture), // R1
    .mask(ts_low_stamp_pkg::MINUTES_MASK),
    .din(clockMinutes),
    .q(stampMinutes)
  );

  bcd_stamp_reg hoursStamp (
    .mclk(mclk),
    .srst(srst),
    .clear(clearPulse),
    .load(capture), // R3
    .mask(ts_low_stamp_pkg::HOURS_MASK),
    .din(clockHours),
    .q(stampHours)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign awready = s.awReady;
  assign wready = s.wReady;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arReady;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;

endmodule : temp_low_stamp_min_hour
`default_nettype wire

/* test/temp_low_stamp_properties.sv */
// checker of stamp register read and write answers
`timescale 1ns/10ps
`default_nettype none
module temp_low_stamp_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [9:0] awaddr,
  input wire logic awvalid,
  input wire logic [9:0] araddr,
  input wire logic arvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic [1:0] bresp,
  input wire logic bvalid
);
  logic [9:0] lastAr;
  logic [9:0] lastAw;
  always_ff @(posedge mclk) begin
    if (arvalid) lastAr <= araddr;
    if (awvalid) lastAw <= awaddr;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence minRead; rvalid && lastAr == 10'h068; endsequence
  sequence hrRead; rvalid && lastAr == 10'h06c; endsequence
  a_min_top: assert property (minRead |-> rdata[31:7] == 25'h0) else $error("minutes top bits");
  a_min_bcd: assert property (minRead |-> rdata[6:4] <= 3'h5 && rdata[3:0] <= 4'h9) else $error("minutes bcd");
  a_hr_top: assert property (hrRead |-> rdata[31:6] == 26'h0) else $error("hours top bits");
  a_hr_bcd: assert property (hrRead |-> rdata[5:0] <= 6'h23 && rdata[3:0] <= 4'h9) else $error("hours bcd");
  a_hr_okay: assert property (hrRead |-> rresp == 2'b00) else $error("hours read resp");
  a_min_okay: assert property (minRead |-> rresp == 2'b00) else $error("minutes read resp");
  a_ro_okay: assert property (bvalid && lastAw[9:3] == 7'h0d |-> bresp == 2'b00) else $error("ro write resp");
endmodule : temp_low_stamp_properties
bind temp_low_stamp_min_hour temp_low_stamp_properties chk_u (.mclk(mclk), .srst(srst), .awaddr(awaddr),
  .awvalid(awvalid), .araddr(araddr), .arvalid(arvalid), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .bresp(bresp), .bvalid(bvalid));
`default_nettype wire

/* test/axil_host.sv */
// axi4-lite host model with read and write tasks
`timescale 1ns/10ps
`default_nettype none
module axil_host (
  input wire logic mclk,
  output logic [9:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [9:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  int lag = 0;
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  task automatic wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, 4'hf, 2'b11};
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    repeat (lag) @(posedge mclk);
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    {araddr, arvalid} <= {a, 1'b1};
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    repeat (lag) @(posedge mclk);
    rready <= 1'b1;
    do @(posedge mclk); while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd
endmodule : axil_host
`default_nettype wire

/* test/temp_low_stamp_min_hour_test.sv */
// testbench of the low-temperature minutes and hours stamp
`timescale 1ns/10ps
`default_nettype none
module temp_low_stamp_min_hour_test;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] clockMinutes = 8'h00;
  logic [7:0] clockHours = 8'h00;
  logic lowEvent = 1'b0;
  int errorCnt = 0;
  int checkCount = 0;
  int cyc = 0;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  axil_host host_u (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  temp_low_stamp_min_hour dut_u (.mclk(mclk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .clockMinutes(clockMinutes), .clockHours(clockHours),
    .lowEvent(lowEvent));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task ev(input logic [7:0] m, input logic [7:0] h);
    @(posedge mclk);
    {clockMinutes, clockHours, lowEvent} <= {m, h, 1'b1};
    @(posedge mclk);
    lowEvent <= 1'b0;
  endtask : ev
  task stamps(input logic [7:0] m, input logic [7:0] h);
    host_u.rd(10'h068, rv, rs);
    chk(rv, {24'h0, m});
    host_u.rd(10'h06c, rv, rs);
    chk(rv, {24'h0, h});
  endtask : stamps
  task t_reset;
    stamps(8'h00, 8'h00);
    host_u.rd(10'h000, rv, rs);
    chk({rv[29:0], rs}, 32'h3);
    $display("test reset done");
  endtask : t_reset
  task t_first;
    host_u.wr(10'h040, 32'h1, rs);
    ev(8'h59, 8'h23);
    stamps(8'h59, 8'h23);
    ev(8'h12, 8'h08);
    stamps(8'h59, 8'h23);
    host_u.rd(10'h040, rv, rs);
    chk(rv, 32'h9);
    $display("test first done");
  endtask : t_first
  task t_last;
    host_u.lag = 3;
    host_u.wr(10'h040, 32'h3, rs);
    ev(8'h07, 8'h19);
    stamps(8'h07, 8'h19);
    ev(8'h60, 8'h24);
    stamps(8'h07, 8'h19);
    ev(8'h3a, 8'h1f);
    stamps(8'h07, 8'h19);
    host_u.lag = 0;
    $display("test last done");
  endtask : t_last
  task t_ro;
    host_u.wr(10'h068, 32'hff, rs);
    chk({30'h0, rs}, 32'h0);
    host_u.wr(10'h06c, 32'hff, rs);
    stamps(8'h07, 8'h19);
    $display("test read-only done");
  endtask : t_ro
  task t_clear;
    host_u.wr(10'h040, 32'h4, rs);
    stamps(8'h00, 8'h00);
    host_u.rd(10'h040, rv, rs);
    chk(rv, 32'h0);
    ev(8'h33, 8'h11);
    stamps(8'h00, 8'h00);
    $display("test clear done");
  endtask : t_clear
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_first;
    t_last;
    t_ro;
    t_clear;
    tally_and_finish;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errorCnt++;
      tally_and_finish;
    end
  end
endmodule : temp_low_stamp_min_hour_test
`default_nettype wire
